/* File: design/wwd_regs.svh */
// Register offsets, field positions, reset values and timing counts of the window watchdog.
// Assumes byte addressing with one aligned 32-bit word per register.
`ifndef WWD_REGS_SVH
`define WWD_REGS_SVH

`define WWD_ADDR_W          8
`define WWD_OFS_KEY         8'h00
`define WWD_OFS_CTL         8'h04
`define WWD_OFS_STATUS      8'h08
`define WWD_OFS_COUNT       8'h0C
`define WWD_OFS_MASK        8'h10

`define WWD_CTL_EN_BIT      0
`define WWD_CTL_IRQEN_BIT   1
`define WWD_CTL_PSC_LSB     8
`define WWD_CTL_PSC_W       4
`define WWD_CTL_CMP_LSB     16
`define WWD_CTL_CMP_W       6
`define WWD_CTL_DBG_BIT     31
`define WWD_STAT_MATCH_BIT  0

`define WWD_CTL_RESET       32'h003F0800
`define WWD_COUNT_RESET     6'h3F
`define WWD_MASK_RESET      1'h1
`define WWD_RELOAD_KEY      32'h00005AA5

`define WWD_SRC_SYS         2'h0
`define WWD_SRC_OSC         2'h1
`define WWD_SYS_DIV         2048
`define WWD_RELOAD_SYNC     3

`define WWD_RESP_OKAY       2'h0
`define WWD_RESP_DECERR     2'h3

`endif

/* File: design/wwd_pkg.sv */
// Types shared by the window watchdog and its bench.
// Assumes wwd_regs.svh is on the include path.
`include "wwd_regs.svh"

package wwd_pkg;

    typedef enum logic [1:0]
    {
        WWD_IDLE   = 2'h0,
        WWD_RUN    = 2'h1,
        WWD_RELOAD = 2'h3,
        WWD_TRIP   = 2'h2
    } wwd_mode_t;

    typedef struct packed
    {
        logic                   awvalid;
        logic [`WWD_ADDR_W-1:0] awaddr;
        logic                   wvalid;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bready;
        logic                   arvalid;
        logic [`WWD_ADDR_W-1:0] araddr;
        logic                   rready;
    } wwd_axi_req_t;

    typedef struct packed
    {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } wwd_axi_rsp_t;

    typedef struct packed
    {
        wwd_mode_t                mode;
        logic                     ctl_written;
        logic                     ctl_en;
        logic                     ctl_irqen;
        logic [`WWD_CTL_PSC_W-1:0] ctl_psc;
        logic [`WWD_CTL_CMP_W-1:0] ctl_cmp;
        logic                     ctl_dbg;
        logic                     flag;
        logic                     mask;
        logic [5:0]               count;
        logic [11:0]              div_cnt;
        logic [11:0]              psc_cnt;
        logic [1:0]               sync_cnt;
        logic                     osc_s1;
        logic                     osc_s2;
        logic                     osc_prev;
        logic                     aw_held;
        logic [`WWD_ADDR_W-1:0]   aw_addr;
        logic                     w_held;
        logic [31:0]              wdata;
        logic [3:0]               wstrb;
        logic                     bvalid;
        logic [1:0]               bresp;
        logic                     rvalid;
        logic [31:0]              rdata;
        logic [1:0]               rresp;
    } wwd_state_t;

endpackage

/* File: design/wwd_top.sv */
// Window watchdog: 6-bit down counter, prescaler, window check, AXI4-Lite registers.
// Assumes clock gate, source select and debug halt come from logic on clk;
// the low-speed oscillator arrives as an asynchronous pin.
`timescale 1ns/1ps
`include "wwd_regs.svh"

// What this block does
// - Counting ticks come from clk divided by 2048 or the low-speed oscillator.
// - Runs only with the clock gate set; selector picks the tick source.
// - Six-bit down counter steps once per prescaled tick.
// - Four-bit prescale code maps to 1,2,4,...,1536,2048.
// - Enabling starts the count at 0x3F toward zero.
// - Control register takes one write after reset; later writes ignored.
// - Once enabled, enable, prescale and compare value cannot change.
// - Match flag sets when count equals compare value; software clears it.
// - Interrupt enable bit lets the match flag raise the interrupt.
// - Key 0x00005AA5 in reload register reloads counter to 0x3F.
// - Counter reaching zero without reload requests system reset.
// - Key written while count above compare value requests reset at once.
// - Reload takes effect after three counting clock ticks.
// - Live count readable, 0x3F after reset.
// - Counter stops decrementing during debug halt unless hold-disable bit set; a pending reload still lands.
module wwd_top
#(
    parameter int SYS_DIV     = `WWD_SYS_DIV,
    parameter int RELOAD_SYNC = `WWD_RELOAD_SYNC
)
(
    input  wire logic                  clk,
    input  wire logic                  reset_n,
    input  wire wwd_pkg::wwd_axi_req_t axi_req,
    output wwd_pkg::wwd_axi_rsp_t      axi_rsp,
    input  wire logic                  peripheral_clock_gate,
    input  wire logic [1:0]            count_clock_source_select,
    input  wire logic                  low_speed_internal_osc,
    input  wire logic                  cpu_debug_halt,
    output logic                       sys_reset_req,
    output logic                       irq
);

    localparam logic [31:0] CTL_RST = `WWD_CTL_RESET;
    localparam logic [11:0] DIV_LAST  = 12'(SYS_DIV - 1);
    localparam logic [1:0]  SYNC_LAST = 2'(RELOAD_SYNC - 1);

    wwd_pkg::wwd_state_t st;
    wwd_pkg::wwd_state_t next_st;

    logic                   src_tick;
    logic                   halted;
    logic                   counting;
    logic                   dec_tick;
    logic                   load_evt;
    logic                   match_evt;
    logic                   reload_done;
    logic                   aw_fire;
    logic                   w_fire;
    logic                   do_write;
    logic [`WWD_ADDR_W-1:0] wr_addr;
    logic [31:0]            wr_data;
    logic [3:0]             wr_strb;
    logic                   key_write;
    logic                   key_hit;
    logic [31:0]            ctl_word;
    logic [31:0]            ctl_new;

    // Prescale code to divide value
    function automatic logic [11:0] prescale_value(input logic [3:0] code);
        logic [11:0] v;
        v = 12'h001;
        unique case (code)
            4'h0: v = 12'h001;
            4'h1: v = 12'h002;
            4'h2: v = 12'h004;
            4'h3: v = 12'h008;
            4'h4: v = 12'h010;
            4'h5: v = 12'h020;
            4'h6: v = 12'h040;
            4'h7: v = 12'h080;
            4'h8: v = 12'h0C0;
            4'h9: v = 12'h100;
            4'hA: v = 12'h180;
            4'hB: v = 12'h200;
            4'hC: v = 12'h300;
            4'hD: v = 12'h400;
            4'hE: v = 12'h600;
            4'hF: v = 12'h800;
        endcase
        return v;
    endfunction

    function automatic logic addr_mapped(input logic [`WWD_ADDR_W-1:0] a);
        logic [`WWD_ADDR_W-1:0] w;
        w = {a[`WWD_ADDR_W-1:2], 2'h0};
        return (w == `WWD_OFS_KEY) || (w == `WWD_OFS_CTL) || (w == `WWD_OFS_STATUS)
            || (w == `WWD_OFS_COUNT) || (w == `WWD_OFS_MASK);
    endfunction

    function automatic logic [`WWD_ADDR_W-1:0] word_addr(input logic [`WWD_ADDR_W-1:0] a);
        return {a[`WWD_ADDR_W-1:2], 2'h0};
    endfunction

    // Current control word as software sees it
    always_comb
    begin
        ctl_word = 32'h00000000;
        ctl_word[`WWD_CTL_EN_BIT] = st.ctl_en;
        ctl_word[`WWD_CTL_IRQEN_BIT] = st.ctl_irqen;
        ctl_word[`WWD_CTL_PSC_LSB +: `WWD_CTL_PSC_W] = st.ctl_psc;
        ctl_word[`WWD_CTL_CMP_LSB +: `WWD_CTL_CMP_W] = st.ctl_cmp;
        ctl_word[`WWD_CTL_DBG_BIT] = st.ctl_dbg;
    end

    always_comb
    begin
        next_st = st;

        // Oscillator pin: two flops, then a third for the edge
        next_st.osc_s1 = low_speed_internal_osc;
        next_st.osc_s2 = st.osc_s1;
        next_st.osc_prev = st.osc_s2;

        if (peripheral_clock_gate && count_clock_source_select == `WWD_SRC_SYS)
        begin
            next_st.div_cnt = (st.div_cnt == DIV_LAST) ? 12'h000 : st.div_cnt + 12'h001;
        end
        else
        begin
            next_st.div_cnt = 12'h000;
        end
        src_tick = peripheral_clock_gate
            && (((count_clock_source_select == `WWD_SRC_SYS) && (st.div_cnt == DIV_LAST))
            || ((count_clock_source_select == `WWD_SRC_OSC) && st.osc_s2 && !st.osc_prev));

        halted = cpu_debug_halt && !st.ctl_dbg;
        counting = ((st.mode == wwd_pkg::WWD_RUN) || (st.mode == wwd_pkg::WWD_RELOAD))
            && !halted;

        dec_tick = counting && src_tick
            && (st.psc_cnt == prescale_value(st.ctl_psc) - 12'h001);
        if (counting && src_tick)
        begin
            next_st.psc_cnt = dec_tick ? 12'h000 : st.psc_cnt + 12'h001;
        end

        // AXI write side: address and data taken in either order
        aw_fire = axi_req.awvalid && !st.aw_held && !st.bvalid;
        w_fire = axi_req.wvalid && !st.w_held && !st.bvalid;
        wr_addr = st.aw_held ? st.aw_addr : axi_req.awaddr;
        wr_data = st.w_held ? st.wdata : axi_req.wdata;
        wr_strb = st.w_held ? st.wstrb : axi_req.wstrb;
        do_write = (st.aw_held || aw_fire) && (st.w_held || w_fire);
        if (st.bvalid && axi_req.bready)
        begin
            next_st.bvalid = 1'b0;
        end
        if (do_write)
        begin
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = addr_mapped(wr_addr) ? `WWD_RESP_OKAY : `WWD_RESP_DECERR;
        end
        else
        begin
            if (aw_fire)
            begin
                next_st.aw_held = 1'b1;
                next_st.aw_addr = axi_req.awaddr;
            end
            if (w_fire)
            begin
                next_st.w_held = 1'b1;
                next_st.wdata = axi_req.wdata;
                next_st.wstrb = axi_req.wstrb;
            end
        end

        key_write = do_write && (word_addr(wr_addr) == `WWD_OFS_KEY);
        key_hit = key_write && (wr_strb == 4'hF) && (wr_data == `WWD_RELOAD_KEY);

        // first control write only, byte lanes honoured
        ctl_new = ctl_word;
        for (int b = 0; b < 4; b++)
        begin
            if (wr_strb[b])
            begin
                ctl_new[b*8 +: 8] = wr_data[b*8 +: 8];
            end
        end
        if (do_write && (word_addr(wr_addr) == `WWD_OFS_CTL) && !st.ctl_written)
        begin
            next_st.ctl_written = 1'b1;
            next_st.ctl_en = ctl_new[`WWD_CTL_EN_BIT];
            next_st.ctl_irqen = ctl_new[`WWD_CTL_IRQEN_BIT];
            next_st.ctl_psc = ctl_new[`WWD_CTL_PSC_LSB +: `WWD_CTL_PSC_W];
            next_st.ctl_cmp = ctl_new[`WWD_CTL_CMP_LSB +: `WWD_CTL_CMP_W];
            next_st.ctl_dbg = ctl_new[`WWD_CTL_DBG_BIT];
        end
        if (do_write && (word_addr(wr_addr) == `WWD_OFS_MASK) && wr_strb[0])
        begin
            next_st.mask = wr_data[`WWD_STAT_MATCH_BIT];
        end

        // Counter sequence
        load_evt = 1'b0;
        reload_done = 1'b0;
        unique case (st.mode)
            wwd_pkg::WWD_IDLE:
            begin
                if (next_st.ctl_en)
                begin
                    next_st.mode = wwd_pkg::WWD_RUN;
                    next_st.count = `WWD_COUNT_RESET;
                    next_st.psc_cnt = 12'h000;
                    load_evt = 1'b1;
                end
            end
            wwd_pkg::WWD_RUN:
            begin
                if (dec_tick)
                begin
                    next_st.count = st.count - 6'h01;
                end
                if (key_hit && (st.count > st.ctl_cmp))
                begin
                    next_st.mode = wwd_pkg::WWD_TRIP;
                end
                // key inside the window starts a reload
                else if (key_hit)
                begin
                    next_st.mode = wwd_pkg::WWD_RELOAD;
                    next_st.sync_cnt = 2'h0;
                end
                if (dec_tick && (st.count == 6'h01))
                begin
                    next_st.mode = wwd_pkg::WWD_TRIP;
                end
            end
            wwd_pkg::WWD_RELOAD:
            begin
                // reload lands on the third counting tick
                reload_done = src_tick && (st.sync_cnt == SYNC_LAST);
                if (src_tick)
                begin
                    next_st.sync_cnt = st.sync_cnt + 2'h1;
                end
                // Reload beats a decrement on the same tick
                if (reload_done)
                begin
                    next_st.mode = wwd_pkg::WWD_RUN;
                    next_st.count = `WWD_COUNT_RESET;
                    next_st.psc_cnt = 12'h000;
                    load_evt = 1'b1;
                end
                else if (dec_tick)
                begin
                    next_st.count = st.count - 6'h01;
                    if (st.count == 6'h01)
                    begin
                        next_st.mode = wwd_pkg::WWD_TRIP;
                    end
                end
            end
            wwd_pkg::WWD_TRIP:
            begin
                next_st.mode = wwd_pkg::WWD_TRIP;
            end
        endcase

        // match sets, set wins over write-one-clear
        match_evt = (load_evt || (dec_tick && !reload_done))
            && (next_st.count == next_st.ctl_cmp);
        if (do_write && (word_addr(wr_addr) == `WWD_OFS_STATUS)
            && wr_strb[0] && wr_data[`WWD_STAT_MATCH_BIT])
        begin
            next_st.flag = 1'b0;
        end
        if (match_evt)
        begin
            next_st.flag = 1'b1;
        end

        // AXI read side, one cycle to answer
        if (st.rvalid && axi_req.rready)
        begin
            next_st.rvalid = 1'b0;
        end
        if (axi_req.arvalid && !st.rvalid)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = addr_mapped(axi_req.araddr) ? `WWD_RESP_OKAY : `WWD_RESP_DECERR;
            unique case (word_addr(axi_req.araddr))
                `WWD_OFS_CTL:    next_st.rdata = ctl_word;
                `WWD_OFS_STATUS: next_st.rdata = {31'h00000000, st.flag};
                `WWD_OFS_COUNT:  next_st.rdata = {26'h0000000, st.count};
                `WWD_OFS_MASK:   next_st.rdata = {31'h00000000, st.mask};
                default:         next_st.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            st <= '0;
            st.mode <= wwd_pkg::WWD_IDLE;
            st.ctl_psc <= CTL_RST[`WWD_CTL_PSC_LSB +: `WWD_CTL_PSC_W];
            st.ctl_cmp <= CTL_RST[`WWD_CTL_CMP_LSB +: `WWD_CTL_CMP_W];
            st.count <= `WWD_COUNT_RESET;
            st.mask <= `WWD_MASK_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign axi_rsp.awready = !st.aw_held && !st.bvalid;
    assign axi_rsp.wready = !st.w_held && !st.bvalid;
    assign axi_rsp.bvalid = st.bvalid;
    assign axi_rsp.bresp = st.bresp;
    assign axi_rsp.arready = !st.rvalid;
    assign axi_rsp.rvalid = st.rvalid;
    assign axi_rsp.rdata = st.rdata;
    assign axi_rsp.rresp = st.rresp;

    // Reset request stays up until the chip reset clears it
    assign sys_reset_req = (st.mode == wwd_pkg::WWD_TRIP);
    // interrupt gated by enable bit and mask
    assign irq = st.flag && st.mask && st.ctl_irqen;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_ctl_write_once: assert property (st.ctl_written |=> $stable(ctl_word))
        else $error("control word changed after its single write");
    a_enable_sticks: assert property (st.ctl_en |=> st.ctl_en && $stable(st.ctl_cmp))
        else $error("enable or compare value changed while counting");
    a_idle_count_max: assert property (st.mode == wwd_pkg::WWD_IDLE |-> st.count == 6'h3F)
        else $error("count left 0x3F before enable");
    a_count_step: assert property (
        (st.mode == wwd_pkg::WWD_RUN) && !dec_tick && !key_hit |=> $stable(st.count))
        else $error("count moved without a prescaled tick");
    a_prescale_bound: assert property (
        st.psc_cnt < prescale_value(st.ctl_psc))
        else $error("prescaler passed its selected value");
    a_gate_stops: assert property (
        !peripheral_clock_gate |-> !src_tick && !dec_tick)
        else $error("tick produced with clock gate off");
    a_match_sets: assert property (match_evt |=> st.flag)
        else $error("match event lost");
    a_irq_cause: assert property (irq |-> st.flag && st.ctl_irqen)
        else $error("interrupt without enabled flag");
    a_zero_trips: assert property (
        (st.mode != wwd_pkg::WWD_IDLE) && (st.count == 6'h00) |-> sys_reset_req)
        else $error("count at zero without reset request");
    a_window_trip: assert property (
        (st.mode == wwd_pkg::WWD_RUN) && key_hit && (st.count > st.ctl_cmp)
        |=> sys_reset_req)
        else $error("key above window did not trip");
    a_reload_lands: assert property (
        reload_done |=> (st.count == 6'h3F) && (st.mode == wwd_pkg::WWD_RUN))
        else $error("reload did not restore 0x3F");
    a_reload_wait: assert property (
        $rose(st.mode == wwd_pkg::WWD_RELOAD) |-> st.sync_cnt == 2'h0)
        else $error("reload sync did not restart");
    a_halt_holds: assert property (
        (st.mode == wwd_pkg::WWD_RUN) && halted |=> $stable(st.count))
        else $error("count moved during debug halt");
    a_bad_key_inert: assert property (
        key_write && !key_hit && (st.mode == wwd_pkg::WWD_RUN) && !dec_tick
        |=> st.mode == wwd_pkg::WWD_RUN)
        else $error("non-key write changed the sequence");

    c_enable: cover property (st.mode == wwd_pkg::WWD_IDLE ##1 st.mode == wwd_pkg::WWD_RUN);
    c_reload: cover property (reload_done);
    c_window_trip: cover property (key_hit && (st.count > st.ctl_cmp));
    c_irq: cover property ($rose(irq));

endmodule

/* File: verif/wwd_top_test.sv */
// Self-checking bench for the window watchdog, driving AXI4-Lite from tasks.
// Assumes wwd_pkg and wwd_regs.svh are compiled first; the bench toggles the oscillator pin.
`timescale 1ns/1ps
`include "wwd_regs.svh"

module wwd_top_test;
    logic                  clk;
    logic                  reset_n;
    wwd_pkg::wwd_axi_req_t req;
    wwd_pkg::wwd_axi_rsp_t rsp;
    logic                  gate;
    logic                  halt;
    logic [1:0]            src_sel;
    logic                  osc;
    logic                  rst_req;
    logic                  irq;
    int                    n_fail;
    int                    checks;
    int                    c;
    logic [31:0]           d;
    logic [31:0]           d1;
    logic [1:0]            r;
    logic [7:0]            ra [5];
    logic [31:0]           rv [5];

    // Short tick divider keeps each run to a few hundred cycles
    wwd_top #(.SYS_DIV(8), .RELOAD_SYNC(3)) dut
    (
        .clk                       (clk),
        .reset_n                   (reset_n),
        .axi_req                   (req),
        .axi_rsp                   (rsp),
        .peripheral_clock_gate     (gate),
        .count_clock_source_select (src_sel),
        .low_speed_internal_osc    (osc),
        .cpu_debug_halt            (halt),
        .sys_reset_req             (rst_req),
        .irq                       (irq)
    );

    initial
    begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    task automatic end_sim();
        if (n_fail == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic timeout();
        n_fail++;
        $display("ERROR %0t timeout", $time);
        end_sim();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR %0t %s", $time, m);
        end
    endtask

    task automatic rng(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi,
                       input string m);
        chk({31'h0, v >= lo && v <= hi}, 32'h1, m);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
        int   i;
        logic ha;
        logic hw;
        logic hb;
        @(posedge clk);
        req.awvalid <= 1'h1;
        req.wvalid  <= 1'h1;
        req.awaddr  <= a;
        req.wdata   <= dat;
        req.wstrb   <= 4'hF;
        req.bready  <= 1'h1;
        for (i = 0; i < 40; i++)
        begin
            @(negedge clk);
            ha = req.awvalid && rsp.awready;
            hw = req.wvalid && rsp.wready;
            hb = rsp.bvalid;
            resp = rsp.bresp;
            @(posedge clk);
            if (ha)
                req.awvalid <= 1'h0;
            if (hw)
                req.wvalid <= 1'h0;
            if (hb)
            begin
                req.bready <= 1'h0;
                break;
            end
        end
        if (i == 40)
            timeout();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
        int   i;
        logic ha;
        logic hr;
        @(posedge clk);
        req.arvalid <= 1'h1;
        req.araddr  <= a;
        req.rready  <= 1'h1;
        for (i = 0; i < 40; i++)
        begin
            @(negedge clk);
            ha = req.arvalid && rsp.arready;
            hr = rsp.rvalid;
            dat = rsp.rdata;
            resp = rsp.rresp;
            @(posedge clk);
            if (ha)
                req.arvalid <= 1'h0;
            if (hr)
            begin
                req.rready <= 1'h0;
                break;
            end
        end
        if (i == 40)
            timeout();
    endtask

    // Waits for irq (sel 1) or the reset request (sel 0), counting cycles
    task automatic wt(input logic sel, input int n, output int cyc);
        for (cyc = 0; cyc < n; cyc++)
        begin
            @(negedge clk);
            if ((sel ? irq : rst_req) === 1'h1)
                break;
        end
        if (cyc == n)
            timeout();
    endtask

    // Control is write-once, so every run starts from a fresh reset
    task automatic rst();
        @(posedge clk);
        reset_n <= 1'h0;
        req     <= '0;
        gate    <= 1'h1;
        halt    <= 1'h0;
        src_sel <= 2'h0;
        osc     <= 1'h0;
        repeat (12) @(posedge clk);
        reset_n <= 1'h1;
    endtask

    initial
    begin
        reset_n = 1'h0;
        req = '0;
        gate = 1'h1;
        halt = 1'h0;
        src_sel = 2'h0;
        osc = 1'h0;
        n_fail = 0;
        checks = 0;
        ra = '{`WWD_OFS_KEY, `WWD_OFS_CTL, `WWD_OFS_STATUS, `WWD_OFS_COUNT, `WWD_OFS_MASK};
        rv = '{32'h0, `WWD_CTL_RESET, 32'h0, 32'h3F, 32'h1};
        rst();
        for (int k = 0; k < 5; k++)
        begin
            rd(ra[k], d, r);
            chk(d, rv[k], "reset value");
        end
        rd(8'h14, d, r);
        chk({30'h0, r}, 32'h3, "unmapped read");
        wr(8'h14, 32'h1, r);
        chk({30'h0, r}, 32'h3, "unmapped write");
        wr(`WWD_OFS_COUNT, 32'h5, r);
        rd(`WWD_OFS_COUNT, d, r);
        chk(d, 32'h3F, "count writable");
        // Run with psc 1, cmp 0x10, irq enabled
        wr(`WWD_OFS_CTL, 32'h00100003, r);
        wr(`WWD_OFS_CTL, 32'h0, r);
        rd(`WWD_OFS_CTL, d, r);
        chk(d, 32'h00100003, "ctl rewritten");
        rd(`WWD_OFS_COUNT, d, r);
        rng(d, 32'h3D, 32'h3F, "start count");
        wt(1'h1, 600, c);
        rd(`WWD_OFS_COUNT, d, r);
        rng(d, 32'h0F, 32'h10, "match count");
        rd(`WWD_OFS_STATUS, d, r);
        chk(d, 32'h1, "flag");
        wr(`WWD_OFS_MASK, 32'h0, r);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(`WWD_OFS_MASK, 32'h1, r);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        wr(`WWD_OFS_KEY, 32'h00005AA4, r);
        repeat (30) @(posedge clk);
        rd(`WWD_OFS_COUNT, d, r);
        rng(d, 32'h1, 32'h0F, "bad key reloaded");
        chk({31'h0, rst_req}, 32'h0, "bad key reset");
        wr(`WWD_OFS_KEY, `WWD_RELOAD_KEY, r);
        rd(`WWD_OFS_COUNT, d, r);
        rng(d, 32'h1, 32'h0F, "reload too early");
        repeat (40) @(posedge clk);
        rd(`WWD_OFS_COUNT, d, r);
        rng(d, 32'h3C, 32'h3F, "no reload");
        chk({31'h0, rst_req}, 32'h0, "reload reset");
        wr(`WWD_OFS_STATUS, 32'h1, r);
        chk({31'h0, irq}, 32'h0, "irq after clear");
        rd(`WWD_OFS_COUNT, d1, r);
        repeat (80) @(posedge clk);
        rd(`WWD_OFS_COUNT, d, r);
        rng(d1 - d, 32'h9, 32'hB, "step rate psc 1");
        // Time-out with debug halt ignored, irq disabled
        rst();
        halt <= 1'h1;
        wr(`WWD_OFS_CTL, 32'h80100001, r);
        wt(1'h0, 600, c);
        rng(c, 32'd480, 32'd520, "time-out length");
        chk({31'h0, irq}, 32'h0, "irq while disabled");
        rd(`WWD_OFS_STATUS, d, r);
        chk(d, 32'h1, "flag at time-out");
        chk({31'h0, rst_req}, 32'h1, "request dropped");
        // Key above window trips at once
        rst();
        wr(`WWD_OFS_CTL, 32'h00100001, r);
        wr(`WWD_OFS_KEY, `WWD_RELOAD_KEY, r);
        wt(1'h0, 4, c);
        // Gate off, then debug hold, then psc 4 rate
        rst();
        gate <= 1'h0;
        halt <= 1'h1;
        wr(`WWD_OFS_CTL, 32'h00100201, r);
        repeat (100) @(posedge clk);
        rd(`WWD_OFS_COUNT, d, r);
        chk(d, 32'h3F, "gate off counted");
        gate <= 1'h1;
        repeat (100) @(posedge clk);
        rd(`WWD_OFS_COUNT, d, r);
        chk(d, 32'h3F, "halt counted");
        halt <= 1'h0;
        repeat (320) @(posedge clk);
        rd(`WWD_OFS_COUNT, d, r);
        rng(32'h3F - d, 32'h9, 32'hB, "step rate psc 4");
        // Oscillator source: 20 rising edges give five steps at psc 4
        src_sel <= 2'h1;
        rd(`WWD_OFS_COUNT, d1, r);
        repeat (40)
        begin
            repeat (4) @(posedge clk);
            osc <= ~osc;
        end
        rd(`WWD_OFS_COUNT, d, r);
        chk(d1 - d, 32'h5, "step rate osc");
        end_sim();
    end
endmodule
